/* File: tb/lwtg_far_model.sv */
// Far-side model: microcontroller transmit, bus transceiver, slow clock
`timescale 1ns/1ps
module lwtg_far_model #(
   parameter int LP_HALF = 4
) (
   input wire logic core_clk,
   input wire logic txd_out,
   output logic lp_clk,
   output logic rxd,
   output logic txd_in
);
   logic wake_drive_n;
   int lp_cnt;

   initial begin
      lp_clk = 1'b0;
      txd_in = 1'b1;
      wake_drive_n = 1'b1;
      lp_cnt = 0;
   end

   // Scaled slow clock, free running so the detector ticks between frames
   always @(posedge core_clk) begin
      if (lp_cnt == LP_HALF - 1) begin
         lp_cnt <= 0;
         lp_clk <= ~lp_clk;
      end else begin
         lp_cnt <= lp_cnt + 1;
      end
   end

   // Wired-AND bus with pull-up: own transmit echoes back
   assign rxd = txd_out & wake_drive_n;

   // Remote master pulls the bus low for n slow ticks
   task automatic rx_low(input int n);
      @(posedge lp_clk);
      @(posedge core_clk);
      wake_drive_n <= 1'b0;
      repeat (n) @(posedge lp_clk);
      @(negedge lp_clk);
      @(posedge core_clk);
      wake_drive_n <= 1'b1;
   endtask

   // Bounded dominant from the controller
   task automatic tx_low(input int n);
      txd_in <= 1'b0;
      repeat (n) @(posedge core_clk);
      txd_in <= 1'b1;
   endtask

   // Stuck-low fault injection on command only
   task automatic tx_set(input logic v);
      txd_in <= v;
   endtask
endmodule

/* File: tb/lwtg_guard_tb.sv */
// Self-checking bench for the wakeup detector and transmit guard
`timescale 1ns/1ps
module lwtg_guard_tb;
   logic core_clk;
   logic rst;
   lwtg_pkg::lwtg_bus_req_t bus_req;
   lwtg_pkg::lwtg_pins_t pins;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic txd_out;
   logic wake_pulse;
   logic irq;
   logic lp_clk;
   logic rxd;
   logic txd_in;
   logic fp;
   logic [31:0] exp_q[$];
   logic [5:0] dly;
   int err_total;
   int tests_run;
   int wake_cnt;
   int cyc;

   assign pins.lp_clk = lp_clk;
   assign pins.rxd = rxd;
   assign pins.txd_in = txd_in;
   assign pins.full_power_state = fp;

   lwtg_guard #(.TX_TIMEOUT_CYC(20)) i_lwtg_guard (
      .core_clk(core_clk),
      .rst(rst),
      .bus_req(bus_req),
      .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest),
      .pins(pins),
      .txd_out(txd_out),
      .wake_pulse(wake_pulse),
      .irq(irq)
   );

   lwtg_far_model i_lwtg_far_model (
      .core_clk(core_clk),
      .txd_out(txd_out),
      .lp_clk(lp_clk),
      .rxd(rxd),
      .txd_in(txd_in)
   );

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task give_verdict;
      if (err_total == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Hold the request until waitrequest is low at a rising edge
   task automatic bus_go(input logic [7:0] a, input logic rd,
                         input logic [31:0] d, input logic be0);
      bus_req.address <= a;
      bus_req.read <= rd;
      bus_req.write <= ~rd;
      // Upper lanes carry noise that the slave must ignore
      bus_req.writedata <= {24'($urandom), d[7:0]};
      bus_req.byteenable <= {3'($urandom), be0};
      do begin
         @(posedge core_clk);
      end while (avs_waitrequest !== 1'b0);
      bus_req.read <= 1'b0;
      bus_req.write <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus_go(a, 1'b1, 32'h0, 1'b1);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus_go(a, 1'b0, d, 1'b1);
   endtask

   // Read answers are matched against the oldest note
   always @(negedge core_clk) begin
      if (bus_req.read === 1'b1 && avs_waitrequest === 1'b0)
         chk(avs_readdata, exp_q.pop_front());
      if (wake_pulse === 1'b1)
         wake_cnt++;
   end

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         give_verdict;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      bus_req = '0;
      fp = 1'b0;
      rst = 1'b1;
      err_total = 0;
      tests_run = 0;
      wake_cnt = 0;
      cyc = 0;
      void'($urandom(32'h1d6f4558));
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk) chk({31'h0, txd_out}, 32'h1);
      @(posedge core_clk);
      rd(lwtg_pkg::ADDR_WAKE_DLY, 32'h14);
      rd(lwtg_pkg::ADDR_IRQ_EN, 32'h0);
      rd(lwtg_pkg::ADDR_SSW, 32'h0);
      // Unmapped holes below the register block
      rd(8'h40 | 8'($urandom % 64), 32'h0);
      wr(8'($urandom % 64), 32'hff);
      // Detection disabled: long low must stay silent
      i_lwtg_far_model.rx_low(40);
      repeat (20) @(posedge core_clk);
      chk(wake_cnt, 0);
      rd(lwtg_pkg::ADDR_IRQ_STAT, 32'h0);
      wr(lwtg_pkg::ADDR_IRQ_EN, 32'h10);
      i_lwtg_far_model.rx_low(19);
      repeat (20) @(posedge core_clk);
      chk(wake_cnt, 0);
      i_lwtg_far_model.rx_low(20);
      repeat (20) @(posedge core_clk);
      chk(wake_cnt, 1);
      @(negedge core_clk) chk({31'h0, irq}, 32'h1);
      @(posedge core_clk);
      rd(lwtg_pkg::ADDR_IRQ_STAT, 32'h10);
      wr(lwtg_pkg::ADDR_IRQ_STAT, 32'h10);
      rd(lwtg_pkg::ADDR_IRQ_STAT, 32'h0);
      // Random delay: one short of it, then exactly it
      dly = 6'(2 + $urandom % 28);
      wr(lwtg_pkg::ADDR_WAKE_DLY, {26'h0, dly});
      rd(lwtg_pkg::ADDR_WAKE_DLY, {26'h0, dly});
      i_lwtg_far_model.rx_low(int'(dly) - 1);
      repeat (20) @(posedge core_clk);
      chk(wake_cnt, 1);
      i_lwtg_far_model.rx_low(int'(dly));
      repeat (20) @(posedge core_clk);
      chk(wake_cnt, 2);
      // Saturation boundary: 20 hex reachable, 21 hex not
      wr(lwtg_pkg::ADDR_WAKE_DLY, 32'h20);
      i_lwtg_far_model.rx_low(40);
      repeat (20) @(posedge core_clk);
      chk(wake_cnt, 3);
      wr(lwtg_pkg::ADDR_WAKE_DLY, 32'h21);
      // Write with lane 0 disabled must not land
      bus_go(lwtg_pkg::ADDR_WAKE_DLY, 1'b0, 32'h05, 1'b0);
      rd(lwtg_pkg::ADDR_WAKE_DLY, 32'h21);
      i_lwtg_far_model.rx_low(40);
      repeat (20) @(posedge core_clk);
      chk(wake_cnt, 3);
      wr(lwtg_pkg::ADDR_IRQ_STAT, 32'h10);
      wr(lwtg_pkg::ADDR_IRQ_EN, 32'h04);
      // Transmit guard
      i_lwtg_far_model.tx_low(40);
      repeat (6) @(posedge core_clk);
      rd(lwtg_pkg::ADDR_SSW, 32'h0);
      fp <= 1'b1;
      repeat (4) @(posedge core_clk);
      i_lwtg_far_model.tx_low(15);
      repeat (2) @(posedge core_clk);
      // One cycle short of the limit
      i_lwtg_far_model.tx_low(19);
      repeat (6) @(posedge core_clk);
      rd(lwtg_pkg::ADDR_SSW, 32'h0);
      i_lwtg_far_model.tx_set(1'b0);
      repeat (30) @(posedge core_clk);
      @(negedge core_clk) chk({31'h0, txd_out}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      @(posedge core_clk);
      rd(lwtg_pkg::ADDR_SSW, 32'h4);
      rd(lwtg_pkg::ADDR_IRQ_STAT, 32'h4);
      rd(lwtg_pkg::ADDR_IRQ_STAT, 32'h0);
      rd(lwtg_pkg::ADDR_SSW, 32'h4);
      @(negedge core_clk) chk({31'h0, txd_out}, 32'h1);
      @(posedge core_clk);
      wr(lwtg_pkg::ADDR_CFG, 32'h02);
      repeat (6) @(posedge core_clk);
      @(negedge core_clk) chk({31'h0, txd_out}, 32'h0);
      @(posedge core_clk);
      rd(lwtg_pkg::ADDR_SSW, 32'h4);
      wr(lwtg_pkg::ADDR_CFG, 32'h00);
      i_lwtg_far_model.tx_set(1'b1);
      repeat (6) @(posedge core_clk);
      wr(lwtg_pkg::ADDR_CFG, 32'h10);
      rd(lwtg_pkg::ADDR_SSW, 32'h0);
      rd(lwtg_pkg::ADDR_CFG, 32'h0);
      i_lwtg_far_model.tx_set(1'b0);
      repeat (8) @(posedge core_clk);
      @(negedge core_clk) chk({31'h0, txd_out}, 32'h0);
      chk({31'h0, irq}, 32'h0);
      @(posedge core_clk);
      i_lwtg_far_model.tx_set(1'b1);
      repeat (4) @(posedge core_clk);
      give_verdict;
   end
endmodule

/* File: verilog/lwtg_guard.sv */
// Bus wakeup detector and transmit dominant-timeout guard
`timescale 1ns/1ps
module lwtg_guard #(
   parameter int unsigned TX_TIMEOUT_CYC = lwtg_pkg::TX_TIMEOUT_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire lwtg_pkg::lwtg_bus_req_t bus_req,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire lwtg_pkg::lwtg_pins_t pins,
   output logic txd_out,
   output logic wake_pulse,
   output logic irq
);
   localparam int TO_W = $clog2(TX_TIMEOUT_CYC + 1);
   localparam logic [TO_W-1:0] TO_LAST = TO_W'(TX_TIMEOUT_CYC - 1);
   localparam logic [TO_W-1:0] TO_FULL = TO_W'(TX_TIMEOUT_CYC);
   localparam int RW = lwtg_pkg::REG_W;
   localparam int WW = lwtg_pkg::WAKE_W;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisation

   // Chain resets to zero; lines idling high pass inverted so that
   // leaving reset does not fake a dominant level on transmit
   localparam lwtg_pkg::lwtg_pins_t PIN_IDLE = 4'h6;

   lwtg_pkg::lwtg_pins_t pins_x;
   lwtg_pkg::lwtg_pins_t pins_s;

   lwtg_sync #(
      .W($bits(lwtg_pkg::lwtg_pins_t))
   ) u_sync (
      .core_clk(core_clk),
      .rst(rst),
      .async_in(pins ^ PIN_IDLE),
      .sync_out(pins_x)
   );

   assign pins_s = pins_x ^ PIN_IDLE;

   ////////////////////////////////////////////////////////////////////
   // State

   logic wait_ff;
   logic [31:0] rdata_ff;
   logic [RW-1:0] stat_ff;
   logic [RW-1:0] en_ff;
   logic [WW-1:0] dly_ff;
   logic ovr_ff;
   logic lp_d_ff;
   logic [WW-1:0] wk_cnt_ff;
   logic [TO_W-1:0] to_cnt_ff;
   logic flag_ff;
   logic txd_ff;
   logic wake_ff;
   logic irq_ff;

   logic nxt_wait;
   logic [31:0] nxt_rdata;
   logic [RW-1:0] nxt_stat;
   logic [RW-1:0] nxt_en;
   logic [WW-1:0] nxt_dly;
   logic nxt_ovr;
   logic nxt_lp_d;
   logic [WW-1:0] nxt_wk_cnt;
   logic [TO_W-1:0] nxt_to_cnt;
   logic nxt_flag;
   logic nxt_txd;
   logic nxt_wake;
   logic nxt_irq;

   logic req;
   logic acc;
   logic wr;
   logic rd;
   logic lp_tick;
   logic wk_en;
   logic wk_hit;
   logic to_run;
   logic to_hit;
   logic clr_to;

   ////////////////////////////////////////////////////////////////////
   // Bus slave: one wait cycle, then the access completes

   always_comb begin
      req = bus_req.read | bus_req.write;
      acc = req & ~wait_ff;
      wr = acc & bus_req.write & bus_req.byteenable[0];
      rd = acc & bus_req.read;
      nxt_wait = ~(req & wait_ff);
      nxt_rdata = 32'h0000_0000;
      if (req && wait_ff && bus_req.read) begin
         case (bus_req.address)
            lwtg_pkg::ADDR_IRQ_STAT: nxt_rdata = 32'(stat_ff);
            lwtg_pkg::ADDR_IRQ_EN: nxt_rdata = 32'(en_ff);
            lwtg_pkg::ADDR_WAKE_DLY: nxt_rdata = 32'(dly_ff);
            lwtg_pkg::ADDR_SSW: begin
               nxt_rdata[lwtg_pkg::SSW_TX_TIMEOUT_BIT] = flag_ff;
            end
            lwtg_pkg::ADDR_CFG: begin
               nxt_rdata[lwtg_pkg::CFG_OVERRIDE_BIT] = ovr_ff;
            end
            default: nxt_rdata = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Configuration registers

   always_comb begin
      nxt_en = en_ff;
      nxt_dly = dly_ff;
      nxt_ovr = ovr_ff;
      clr_to = 1'b0;
      if (wr) begin
         case (bus_req.address)
            lwtg_pkg::ADDR_IRQ_EN: nxt_en = bus_req.writedata[RW-1:0];
            lwtg_pkg::ADDR_WAKE_DLY: nxt_dly = bus_req.writedata[WW-1:0];
            lwtg_pkg::ADDR_CFG: begin
               nxt_ovr = bus_req.writedata[lwtg_pkg::CFG_OVERRIDE_BIT];
               // Strobe is never stored, so it reads back as zero
               clr_to = bus_req.writedata[lwtg_pkg::CFG_CLR_TIMEOUT_BIT];
            end
            default: nxt_en = en_ff;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Wakeup detector on low-power clock ticks

   always_comb begin
      nxt_lp_d = pins_s.lp_clk;
      lp_tick = pins_s.lp_clk & ~lp_d_ff;
      wk_en = en_ff[lwtg_pkg::IRQ_WAKE_BIT];
      nxt_wk_cnt = wk_cnt_ff;
      wk_hit = 1'b0;
      if (!wk_en) begin
         nxt_wk_cnt = lwtg_pkg::WAKE_CNT_IDLE;
      end else if (lp_tick) begin
         if (pins_s.rxd) begin
            nxt_wk_cnt = lwtg_pkg::WAKE_CNT_ZERO;
         end else if (wk_cnt_ff != lwtg_pkg::WAKE_CNT_IDLE) begin
            nxt_wk_cnt = wk_cnt_ff + 6'h01;
            // Fires once per low period, on entry to the delay value
            wk_hit = (nxt_wk_cnt == dly_ff);
         end
      end
      nxt_wake = wk_hit;
   end

   ////////////////////////////////////////////////////////////////////
   // Transmit dominant timeout

   always_comb begin
      to_run = pins_s.full_power_state & ~pins_s.txd_in;
      to_hit = to_run && (to_cnt_ff == TO_LAST);
      if (!to_run) begin
         nxt_to_cnt = '0;
      end else if (to_cnt_ff == TO_FULL) begin
         // Saturate so a long low does not retrigger the status bit
         nxt_to_cnt = to_cnt_ff;
      end else begin
         nxt_to_cnt = to_cnt_ff + TO_W'(1);
      end
      // Detection wins over a clear in the same cycle
      if (to_hit) begin
         nxt_flag = 1'b1;
      end else if (clr_to) begin
         nxt_flag = 1'b0;
      end else begin
         nxt_flag = flag_ff;
      end
      nxt_txd = pins_s.txd_in | (flag_ff & ~ovr_ff);
   end

   ////////////////////////////////////////////////////////////////////
   // Interrupt status, mask and output

   always_comb begin
      nxt_stat = stat_ff;
      if (wr && bus_req.address == lwtg_pkg::ADDR_IRQ_STAT) begin
         nxt_stat = stat_ff & ~bus_req.writedata[RW-1:0];
      end
      // Only the timeout bit is cleared by the read, and only if it was reported
      if (rd && bus_req.address == lwtg_pkg::ADDR_IRQ_STAT) begin
         nxt_stat[lwtg_pkg::IRQ_TX_TIMEOUT_BIT] =
            nxt_stat[lwtg_pkg::IRQ_TX_TIMEOUT_BIT] &
            ~rdata_ff[lwtg_pkg::IRQ_TX_TIMEOUT_BIT];
      end
      if (to_hit) begin
         nxt_stat[lwtg_pkg::IRQ_TX_TIMEOUT_BIT] = 1'b1;
      end
      if (wk_hit) begin
         nxt_stat[lwtg_pkg::IRQ_WAKE_BIT] = 1'b1;
      end
      nxt_irq = |(stat_ff & en_ff);
   end

   ////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0000_0000;
         stat_ff <= lwtg_pkg::IRQ_STAT_RST;
         en_ff <= lwtg_pkg::IRQ_EN_RST;
         dly_ff <= lwtg_pkg::WAKE_DLY_RST;
         ovr_ff <= lwtg_pkg::CFG_OVERRIDE_RST;
         lp_d_ff <= 1'b0;
         wk_cnt_ff <= lwtg_pkg::WAKE_CNT_IDLE;
         to_cnt_ff <= '0;
         flag_ff <= 1'b0;
         txd_ff <= 1'b1;
         wake_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
         stat_ff <= nxt_stat;
         en_ff <= nxt_en;
         dly_ff <= nxt_dly;
         ovr_ff <= nxt_ovr;
         lp_d_ff <= nxt_lp_d;
         wk_cnt_ff <= nxt_wk_cnt;
         to_cnt_ff <= nxt_to_cnt;
         flag_ff <= nxt_flag;
         txd_ff <= nxt_txd;
         wake_ff <= nxt_wake;
         irq_ff <= nxt_irq;
      end
   end

   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign txd_out = txd_ff;
   assign wake_pulse = wake_ff;
   assign irq = irq_ff;

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   wake_off_hold_a: assert property (
      !wk_en |=> wk_cnt_ff == lwtg_pkg::WAKE_CNT_IDLE)
      else $error("wakeup counter not parked while disabled");

   wake_off_quiet_a: assert property (
      $rose(stat_ff[lwtg_pkg::IRQ_WAKE_BIT]) |-> $past(wk_en))
      else $error("wakeup status set while detection disabled");

   wake_line_high_a: assert property (
      wk_en && lp_tick && pins_s.rxd |=> wk_cnt_ff == 6'h00)
      else $error("wakeup counter not cleared on high line");

   wake_count_up_a: assert property (
      wk_en && lp_tick && !pins_s.rxd && wk_cnt_ff < 6'h20
      |=> wk_cnt_ff == $past(wk_cnt_ff) + 6'h01)
      else $error("wakeup counter did not advance");

   wake_saturate_a: assert property (
      wk_cnt_ff <= 6'h20)
      else $error("wakeup counter above its ceiling");

   wake_strobe_a: assert property (
      wk_hit |=> stat_ff[lwtg_pkg::IRQ_WAKE_BIT] && wake_ff
      && wk_cnt_ff == dly_ff)
      else $error("wakeup delay match lost");

   to_fp_only_a: assert property (
      !pins_s.full_power_state |=> to_cnt_ff == '0 ##1 !to_hit)
      else $error("timeout measured outside full power");

   to_restart_a: assert property (
      pins_s.txd_in |=> to_cnt_ff == '0)
      else $error("timeout count not restarted on high transmit");

   to_detect_a: assert property (
      to_run && to_cnt_ff == TO_LAST
      |=> flag_ff && stat_ff[lwtg_pkg::IRQ_TX_TIMEOUT_BIT])
      else $error("timeout not declared at the limit");

   txd_forced_a: assert property (
      flag_ff && !ovr_ff |=> txd_ff)
      else $error("transmit not forced high by timeout flag");

   flag_persist_a: assert property (
      flag_ff && !clr_to |=> flag_ff)
      else $error("timeout flag dropped without the strobe");

   flag_clear_a: assert property (
      clr_to && !to_hit |=> !flag_ff)
      else $error("clear strobe did not drop the flag");

   stat_read_clr_a: assert property (
      rd && bus_req.address == lwtg_pkg::ADDR_IRQ_STAT
      && rdata_ff[lwtg_pkg::IRQ_TX_TIMEOUT_BIT] && !to_hit
      |=> !stat_ff[lwtg_pkg::IRQ_TX_TIMEOUT_BIT])
      else $error("status read left the timeout bit set");

   ssw_mirror_a: assert property (
      req && wait_ff && bus_req.read
      && bus_req.address == lwtg_pkg::ADDR_SSW
      |=> avs_readdata[lwtg_pkg::SSW_TX_TIMEOUT_BIT] == $past(flag_ff))
      else $error("status word does not mirror the flag");
endmodule

/* File: verilog/lwtg_pkg.sv */
// Constants, register map and carrier types for the bus wakeup/tx guard
package lwtg_pkg;
   // Timing
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned TX_TIMEOUT_NS = 10240000;
   localparam int unsigned TX_TIMEOUT_CYC =
      (TX_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Widths
   localparam int WAKE_W = 6;
   localparam int REG_W = 8;
   localparam int SYNC_STAGES = 2;

   // Register byte addresses
   localparam logic [7:0] ADDR_IRQ_STAT = 8'ha0;
   localparam logic [7:0] ADDR_IRQ_EN = 8'ha4;
   localparam logic [7:0] ADDR_WAKE_DLY = 8'ha8;
   localparam logic [7:0] ADDR_SSW = 8'hac;
   localparam logic [7:0] ADDR_CFG = 8'hb4;

   // Field positions
   localparam int IRQ_TX_TIMEOUT_BIT = 2;
   localparam int IRQ_WAKE_BIT = 4;
   localparam int SSW_TX_TIMEOUT_BIT = 2;
   localparam int CFG_OVERRIDE_BIT = 1;
   localparam int CFG_CLR_TIMEOUT_BIT = 4;

   // Values after reset and counter marks
   localparam logic [WAKE_W-1:0] WAKE_DLY_RST = 6'h14;
   localparam logic [WAKE_W-1:0] WAKE_CNT_IDLE = 6'h20;
   localparam logic [WAKE_W-1:0] WAKE_CNT_ZERO = 6'h00;
   localparam logic [REG_W-1:0] IRQ_STAT_RST = 8'h00;
   localparam logic [REG_W-1:0] IRQ_EN_RST = 8'h00;
   localparam logic CFG_OVERRIDE_RST = 1'b0;

   // Avalon-MM request from the master
   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } lwtg_bus_req_t;

   // Pins from outside the core clock domain
   typedef struct packed {
      logic lp_clk;
      logic rxd;
      logic txd_in;
      logic full_power_state;
   } lwtg_pins_t;
endpackage

/* File: verilog/lwtg_sync.sv */
// Two-stage synchroniser, one chain per bit
`timescale 1ns/1ps
module lwtg_sync #(
   parameter int W = 4
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   ////////////////////////////////////////////////////////////////////
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_ff;
         logic stab_ff;
         logic nxt_meta;
         logic nxt_stab;
         // First stage is read by the second stage only
         always_comb begin
            nxt_meta = async_in[i];
            nxt_stab = meta_ff;
         end
         always_ff @(posedge core_clk) begin
            if (rst) begin
               meta_ff <= 1'b0;
               stab_ff <= 1'b0;
            end else begin
               meta_ff <= nxt_meta;
               stab_ff <= nxt_stab;
            end
         end
         assign sync_out[i] = stab_ff;
      end
   endgenerate
endmodule
